// ---- hw/lvsrc_pkg.sv ----
// constants and types for the low-voltage and system reset controller
package lvsrc_pkg;
    // register word addresses
    localparam logic [3:0] ADDR_LEVEL = 4'h0; // undervoltage_level_select
    localparam logic [3:0] ADDR_CAUSE = 4'h1; // reset_cause_flags
    localparam logic [3:0] ADDR_PROG = 4'h2; // programming_control_1 (write only)
    localparam logic [3:0] ADDR_STATUS = 4'h3; // watchdog_timeout_flag, power_down_flag
    localparam logic [3:0] ADDR_IRQ_ST = 4'h4; // sticky event status
    localparam logic [3:0] ADDR_IRQ_EN = 4'h5; // event enable
    localparam logic [3:0] ADDR_IRQ_CLR = 4'h6; // write one to clear
    // threshold codes
    localparam logic [7:0] CODE_1V7 = 8'h66;
    localparam logic [7:0] CODE_1V9 = 8'h55;
    localparam logic [7:0] CODE_2V55 = 8'h33;
    localparam logic [7:0] CODE_3V15 = 8'h99;
    localparam logic [7:0] CODE_3V8 = 8'hAA;
    localparam logic [7:0] CODE_OFF = 8'hF0;
    localparam logic [7:0] LEVEL_POR = 8'h66;
    localparam logic [7:0] PROG_RESET_KEY = 8'h55;
    // cause flag positions
    localparam int BIT_REG_FAULT = 3;
    localparam int BIT_UV = 2;
    localparam int BIT_LVL_FAULT = 1;
    localparam int BIT_WDT_FAULT = 0;
    // status register positions
    localparam int BIT_TO = 0;
    localparam int BIT_PDF = 1;
    // event positions in the interrupt registers
    localparam int EV_UV = 0;
    localparam int EV_LVL = 1;
    localparam int EV_PROG = 2;
    localparam int EV_WDT = 3;
    localparam int EV_WDT_LP = 4;
    localparam int EV_W = 5;
    // timing, in ns, and cycle counts at 100 MHz
    localparam int CLK_NS = 10;
    localparam int FILTER_NS = 100;
    localparam int SRST_NS = 100;
    localparam int FILTER_CYC = (FILTER_NS + CLK_NS - 1) / CLK_NS;
    localparam int SRST_CYC = (SRST_NS + CLK_NS - 1) / CLK_NS;
    // soft-reset sequencer states
    typedef enum logic [1:0] {
        LVSRC_IDLE = 2'b00,
        LVSRC_WAIT = 2'b01,
        LVSRC_FIRE = 2'b10
    } lvsrc_state_t;
endpackage

// ---- hw/lvsrc_filter.sv ----
// synchroniser and persistence filter for the undervoltage comparator
`timescale 1ns/1ps
module lvsrc_filter #(
    parameter int CYC = 10
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // control
    input wire logic enable,
    input wire logic raw_low,
    // result
    output logic valid_low
);
    logic sync_a; // first stage, read by sync_b only
    logic sync_b; // second stage
    logic [15:0] count; // persistence counter

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
        end
        else
        begin
            sync_a <= raw_low;
            sync_b <= sync_a;
        end
    end

    // count while the low level persists
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            count <= 16'h0000;
            valid_low <= 1'b0;
        end
        // short dips restart the count
        else if (!enable || !sync_b)
        begin
            count <= 16'h0000;
            valid_low <= 1'b0;
        end
        else if (count > 16'(CYC))
        begin
            valid_low <= 1'b1;
        end
        else
        begin
            count <= count + 16'h0001;
        end
    end
endmodule

// ---- hw/lvsrc_ctrl.sv ----
// low-voltage and system reset controller, top level with Avalon-MM slave
// Operation
// - supervision on unless sleep or idle
// - reset only if low exceeds filter
// - validated low resets, sets cause flag
// - decode five thresholds and disable code
// - undefined code resets after soft delay
// - undefined code reset restores level POR
// - undefined code sets level fault flag
// - undervoltage reset keeps level register
// - level register powers up 0x66
// - cause flags set by hardware, software clears
// - writing 55H to programming control resets
// - normal watchdog timeout resets, sets timeout
// - low-power timeout clears pc/sp, sets flags
`timescale 1ns/1ps
module lvsrc_ctrl #(
    parameter int FILTER_CYCLES = lvsrc_pkg::FILTER_CYC,
    parameter int SRST_CYCLES = lvsrc_pkg::SRST_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // avalon-mm slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // analog comparators, one per threshold, high when supply is below it
    input wire logic [4:0] cmp_low,
    // power mode and watchdog
    input wire logic low_power_mode,
    input wire logic wdt_timeout,
    // reset outputs
    output logic sys_reset,
    output logic pc_sp_clear,
    // threshold selection to the analog side
    output logic [2:0] threshold_sel,
    output logic supervise_en,
    // interrupt
    output logic irq
);
    logic [7:0] undervoltage_level_select; // threshold_code_field
    logic [3:0] reset_cause_flags; // low four bits only
    logic watchdog_timeout_flag;
    logic power_down_flag;
    logic [lvsrc_pkg::EV_W-1:0] irq_status;
    logic [lvsrc_pkg::EV_W-1:0] irq_enable;
    logic [lvsrc_pkg::EV_W-1:0] events; // one-cycle event pulses
    logic served; // one-cycle answer slot
    logic wr_hit; // write accepted this cycle
    logic uv_valid; // filtered undervoltage
    logic uv_filt; // filter output
    logic sel_low; // comparator chosen by the code
    logic code_bad; // undefined level code
    lvsrc_pkg::lvsrc_state_t state;
    lvsrc_pkg::lvsrc_state_t next_state;
    logic [15:0] delay_cnt; // soft-reset delay counter
    logic uv_fire; // undervoltage reset pulse
    logic lvl_fire; // level-fault reset pulse
    logic prog_fire; // programming key reset pulse
    logic wdt_fire; // normal watchdog reset pulse
    logic wdt_lp; // low-power watchdog pulse
    logic uv_seen; // holds off repeat undervoltage resets

    // decode a code into threshold index, 7 when not a threshold
    // index 7 selects no comparator, so the filter sees no low
    function automatic logic [2:0] code_index(input logic [7:0] code);
        case (code)
            lvsrc_pkg::CODE_1V7: code_index = 3'h0;
            lvsrc_pkg::CODE_1V9: code_index = 3'h1;
            lvsrc_pkg::CODE_2V55: code_index = 3'h2;
            lvsrc_pkg::CODE_3V15: code_index = 3'h3;
            lvsrc_pkg::CODE_3V8: code_index = 3'h4;
            default: code_index = 3'h7;
        endcase
    endfunction

    // code is neither a threshold nor the disable code
    function automatic logic code_undefined(input logic [7:0] code);
        code_undefined = (code_index(code) == 3'h7) && (code != lvsrc_pkg::CODE_OFF);
    endfunction

    // the disable code is defined and never starts the soft reset
    // threshold decode
    assign code_bad = code_undefined(undervoltage_level_select);
    assign sel_low = (code_index(undervoltage_level_select) == 3'h7) ? 1'b0
                   : cmp_low[code_index(undervoltage_level_select)];

    // bus handshake: one wait cycle, answer in the next
    // a write lands only in the answer cycle, when waitrequest is low
    assign wr_hit = avs_write && served;

    // answer slot toggles so every request waits exactly one cycle
    // the slot drops after each answer, so back-to-back requests wait again
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            served <= 1'b0;
        else if ((avs_read || avs_write) && !served)
            served <= 1'b1;
        else
            served <= 1'b0;
    end

    // waitrequest is low only in the answer cycle
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            avs_waitrequest <= 1'b1;
        else
            avs_waitrequest <= !((avs_read || avs_write) && !served);
    end

    // read data mux, registered at the first edge of the request
    // captured on the first edge, so it stands through the answer cycle
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            avs_readdata <= 32'h0000_0000;
        else if (avs_read && !served)
        begin
            case (avs_address)
                lvsrc_pkg::ADDR_LEVEL: avs_readdata <= {24'h000000, undervoltage_level_select};
                lvsrc_pkg::ADDR_CAUSE: avs_readdata <= {28'h0000000, reset_cause_flags};
                lvsrc_pkg::ADDR_STATUS: avs_readdata <= {30'h0000_0000, power_down_flag, watchdog_timeout_flag};
                lvsrc_pkg::ADDR_IRQ_ST: avs_readdata <= {27'h0000000, irq_status};
                lvsrc_pkg::ADDR_IRQ_EN: avs_readdata <= {27'h0000000, irq_enable};
                // unmapped and write-only read zero
                default: avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    // undervoltage filter with synchroniser
    // enable low clears the count, so a partial dip is forgotten
    lvsrc_filter #(
        .CYC(FILTER_CYCLES)
    ) u_filter (
        .clk(clk),
        .nrst(nrst),
        .enable(supervise_en),
        .raw_low(sel_low),
        .valid_low(uv_filt)
    );
    assign uv_valid = uv_filt;

    // the select output follows the code even while supervision is off
    // supervision gated by mode and code
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            supervise_en <= 1'b0;
            threshold_sel <= 3'h0;
        end
        else
        begin
            supervise_en <= !low_power_mode && (code_index(undervoltage_level_select) != 3'h7);
            threshold_sel <= code_index(undervoltage_level_select);
        end
    end

    // without this a long dip would request a reset every cycle
    // one reset per validated low interval
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            uv_seen <= 1'b0;
        else
            uv_seen <= uv_valid;
    end
    assign uv_fire = uv_valid && !uv_seen;

    // a later good code does not abort the wait: the fault has happened
    // soft-reset delay sequencer
    always_comb
    begin
        next_state = state;
        case (state)
            lvsrc_pkg::LVSRC_IDLE:
                if (code_bad)
                    next_state = lvsrc_pkg::LVSRC_WAIT;
            lvsrc_pkg::LVSRC_WAIT:
                if (delay_cnt >= 16'(SRST_CYCLES - 1))
                    next_state = lvsrc_pkg::LVSRC_FIRE;
            lvsrc_pkg::LVSRC_FIRE:
                next_state = lvsrc_pkg::LVSRC_IDLE;
            default:
                next_state = lvsrc_pkg::LVSRC_IDLE;
        endcase
    end

    // state register and delay counter
    // the counter runs only while waiting, so each fault gets a full delay
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state <= lvsrc_pkg::LVSRC_IDLE;
            delay_cnt <= 16'h0000;
        end
        else
        begin
            state <= next_state;
            delay_cnt <= (state == lvsrc_pkg::LVSRC_WAIT) ? delay_cnt + 16'h0001 : 16'h0000;
        end
    end
    assign lvl_fire = (state == lvsrc_pkg::LVSRC_FIRE);

    // key compared on the low byte; the upper bits are ignored
    // programming key write
    assign prog_fire = wr_hit && (avs_address == lvsrc_pkg::ADDR_PROG)
                     && (avs_writedata[7:0] == lvsrc_pkg::PROG_RESET_KEY);
    // the watchdog pulse is split by the power mode
    // normal-mode watchdog reset
    assign wdt_fire = wdt_timeout && !low_power_mode;
    assign wdt_lp = wdt_timeout && low_power_mode;

    // level select register
    // a fault reset in the same cycle as a write overrides the write
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            undervoltage_level_select <= lvsrc_pkg::LEVEL_POR;
        else if (lvl_fire || prog_fire || wdt_fire)
            undervoltage_level_select <= lvsrc_pkg::LEVEL_POR;
        else if (wr_hit && avs_address == lvsrc_pkg::ADDR_LEVEL)
            undervoltage_level_select <= avs_writedata[7:0];
    end

    // reset cause flags
    // bits 3 and 0 belong to other fault sources and read zero here
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            reset_cause_flags <= 4'h0;
        else
        begin
            if (wr_hit && avs_address == lvsrc_pkg::ADDR_CAUSE)
                reset_cause_flags <= reset_cause_flags & avs_writedata[3:0];
            if (uv_fire)
                reset_cause_flags[lvsrc_pkg::BIT_UV] <= 1'b1;
            if (lvl_fire)
                reset_cause_flags[lvsrc_pkg::BIT_LVL_FAULT] <= 1'b1;
        end
    end

    // timeout and power-down flags
    // later assignments win, so a timeout beats a clear in one cycle
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            watchdog_timeout_flag <= 1'b0;
            power_down_flag <= 1'b0;
        end
        else
        begin
            // software clears with a zero write
            if (wr_hit && avs_address == lvsrc_pkg::ADDR_STATUS)
            begin
                watchdog_timeout_flag <= watchdog_timeout_flag & avs_writedata[lvsrc_pkg::BIT_TO];
                power_down_flag <= power_down_flag & avs_writedata[lvsrc_pkg::BIT_PDF];
            end
            if (wdt_fire)
                watchdog_timeout_flag <= 1'b1;
            if (wdt_lp)
            begin
                watchdog_timeout_flag <= 1'b1;
                power_down_flag <= 1'b1;
            end
        end
    end

    // reset pulses to the core
    // one-cycle requests; the core sets its own reset length
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sys_reset <= 1'b0;
            pc_sp_clear <= 1'b0;
        end
        else
        begin
            sys_reset <= uv_fire || lvl_fire || prog_fire || wdt_fire;
            pc_sp_clear <= wdt_lp;
        end
    end

    // event vector for the interrupt block
    // bit order follows the event positions in the package
    assign events = {wdt_lp, wdt_fire, prog_fire, lvl_fire, uv_fire};

    // sticky status, set wins over clear
    // an event in the cycle of a clear leaves its bit set
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            irq_status <= '0;
        else if (wr_hit && avs_address == lvsrc_pkg::ADDR_IRQ_CLR)
            irq_status <= (irq_status & ~avs_writedata[lvsrc_pkg::EV_W-1:0]) | events;
        else
            irq_status <= irq_status | events;
    end

    // interrupt enable register
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            irq_enable <= '0;
        else if (wr_hit && avs_address == lvsrc_pkg::ADDR_IRQ_EN)
            irq_enable <= avs_writedata[lvsrc_pkg::EV_W-1:0];
    end

    // level interrupt output
    // one cycle behind the status and enable registers
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            irq <= 1'b0;
        else
            irq <= |(irq_status & irq_enable);
    end
endmodule

// ---- verif/lvsrc_far.sv ----
// comparator bank and watchdog stand-in facing the reset controller
`timescale 1ns/1ps
module lvsrc_far (
    // clock
    input wire logic clk,
    // bench controls
    input wire logic [11:0] supply_mv,
    input wire logic wdt_fire,
    // to the controller
    output logic [4:0] cmp_low,
    output logic wdt_timeout
);
    // trip points in millivolts, lowest first
    localparam logic [11:0] TRIP [5] = '{12'h6A4, 12'h76C, 12'h9F6, 12'hC4E, 12'hED8};
    always_comb
    begin
        for (int i = 0; i < 5; i++)
            cmp_low[i] = (supply_mv < TRIP[i]);
    end
    // overflow seen as a one-cycle pulse
    always @(posedge clk)
        wdt_timeout <= wdt_fire;
endmodule

// ---- verif/lvsrc_ctrl_props.sv ----
// port checker for the reset controller
`timescale 1ns/1ps
module lvsrc_ctrl_chk #(
    parameter int FILTER_CYCLES = 10,
    parameter int SRST_CYCLES = 10
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // register bus
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // far side
    input wire logic [4:0] cmp_low,
    input wire logic low_power_mode,
    input wire logic wdt_timeout,
    // outputs
    input wire logic sys_reset,
    input wire logic pc_sp_clear,
    input wire logic [2:0] threshold_sel,
    input wire logic supervise_en,
    input wire logic irq
);
    // slack on the soft-reset wait
    localparam int SR_MAX = SRST_CYCLES + 4;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // accepted write and its data byte
    logic wr_ok;
    logic [7:0] wb;
    assign wr_ok = avs_write & ~avs_waitrequest;
    assign wb = avs_writedata[7:0];
    property p_por; $rose(nrst) |=> threshold_sel == 3'h0 && supervise_en; endproperty
    a_por: assert property (p_por) else $error("level not lowest after reset");
    property p_lp; low_power_mode [*2] |-> !supervise_en; endproperty
    a_lp: assert property (p_lp) else $error("supervision on in low power");
    property p_sel; wr_ok && avs_address == lvsrc_pkg::ADDR_LEVEL && wb == lvsrc_pkg::CODE_3V8
        |-> ##[1:3] threshold_sel == 3'h4; endproperty
    a_sel: assert property (p_sel) else $error("top code not decoded");
    property p_off; wr_ok && avs_address == lvsrc_pkg::ADDR_LEVEL && wb == lvsrc_pkg::CODE_OFF
        |-> ##[1:3] !supervise_en; endproperty
    a_off: assert property (p_off) else $error("off code kept supervision");
    property p_bad; wr_ok && avs_address == lvsrc_pkg::ADDR_LEVEL && !(wb inside {8'h66, 8'h55, 8'h33,
        8'h99, 8'hAA, 8'hF0}) |-> ##1 !sys_reset [*2] ##[1:SR_MAX] sys_reset; endproperty
    a_bad: assert property (p_bad) else $error("bad code reset timing");
    property p_key; wr_ok && avs_address == lvsrc_pkg::ADDR_PROG && wb == lvsrc_pkg::PROG_RESET_KEY
        |-> ##[1:4] sys_reset; endproperty
    a_key: assert property (p_key) else $error("key write gave no reset");
    property p_wdt; wdt_timeout && !low_power_mode |-> ##[1:4] sys_reset; endproperty
    a_wdt: assert property (p_wdt) else $error("timeout gave no reset");
    property p_lpw; wdt_timeout && low_power_mode |-> ##[1:4] pc_sp_clear; endproperty
    a_lpw: assert property (p_lpw) else $error("no pc clear in low power");
    property p_lpk; wdt_timeout && low_power_mode |-> !sys_reset [*5]; endproperty
    a_lpk: assert property (p_lpk) else $error("full reset in low power");
    // main scenarios reached
    c_rst: cover property (sys_reset);
    c_pc: cover property (pc_sp_clear);
    c_irq: cover property ($rose(irq));
endmodule

bind lvsrc_ctrl lvsrc_ctrl_chk #(.FILTER_CYCLES(FILTER_CYCLES), .SRST_CYCLES(SRST_CYCLES)) u_chk (
    .clk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .cmp_low, .low_power_mode, .wdt_timeout, .sys_reset, .pc_sp_clear,
    .threshold_sel, .supervise_en, .irq
);

// ---- verif/tb.sv ----
// testbench for the reset controller
`timescale 1ns/1ps
module tb;
    // shortened filter and soft-reset counts
    localparam int F = 4;
    localparam int S = 6;
    // clock, reset, bus
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    // far side
    logic [4:0] cmp_low;
    logic low_power_mode = 1'b0;
    logic wdt_timeout;
    logic [11:0] supply_mv = 12'hFA0;
    logic wdt_fire = 1'b0;
    // outputs
    logic sys_reset, pc_sp_clear, supervise_en, irq;
    logic [2:0] threshold_sel;
    // counters and last read
    int err_total = 0, check_count = 0, n_rst = 0, n_pc = 0;
    logic [31:0] rd;

    always #5 clk = ~clk;

    lvsrc_far far (.clk, .supply_mv, .wdt_fire, .cmp_low, .wdt_timeout);
    lvsrc_ctrl #(.FILTER_CYCLES(F), .SRST_CYCLES(S)) dut (
        .clk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
        .avs_waitrequest, .cmp_low, .low_power_mode, .wdt_timeout, .sys_reset, .pc_sp_clear,
        .threshold_sel, .supervise_en, .irq
    );

    // count reset pulses
    always @(posedge clk)
    begin
        if (sys_reset === 1'b1)
            n_rst++;
        if (pc_sp_clear === 1'b1)
            n_pc++;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("ERROR t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
    endtask

    // one bus cycle, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= ~w;
        avs_write <= w;
        do
        begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        // one wait edge plus the accepting edge
        chk(32'(n), 32'h2);
    endtask

    task automatic rchk(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    task automatic t_por();
        rchk(lvsrc_pkg::ADDR_LEVEL, 32'h66);
        chk(32'(threshold_sel), 32'h0);
        rchk(4'hF, 32'h0);
        $display("por done");
    endtask

    task automatic t_decode();
        logic [7:0] c [6];
        c = '{lvsrc_pkg::CODE_1V7, lvsrc_pkg::CODE_1V9, lvsrc_pkg::CODE_2V55, lvsrc_pkg::CODE_3V15,
            lvsrc_pkg::CODE_3V8, lvsrc_pkg::CODE_OFF};
        for (int i = 0; i < 6; i++)
        begin
            bus(1'b1, lvsrc_pkg::ADDR_LEVEL, 32'(c[i]));
            rchk(lvsrc_pkg::ADDR_LEVEL, 32'(c[i]));
            chk(32'(supervise_en), 32'(i < 5));
            if (i < 5)
                chk(32'(threshold_sel), 32'(i));
        end
        $display("decode done");
    endtask

    // short dip ignored, long dip resets and keeps level
    task automatic t_dip();
        int b;
        b = n_rst;
        bus(1'b1, lvsrc_pkg::ADDR_LEVEL, 32'h33);
        supply_mv <= 12'h9C4;
        cyc(F);
        supply_mv <= 12'hFA0;
        cyc(8);
        chk(32'(n_rst - b), 32'h0);
        rchk(lvsrc_pkg::ADDR_CAUSE, 32'h0);
        supply_mv <= 12'h9C4;
        cyc(F + 12);
        supply_mv <= 12'hFA0;
        cyc(4);
        chk(32'(n_rst - b), 32'h1);
        rchk(lvsrc_pkg::ADDR_CAUSE, 32'h4);
        rchk(lvsrc_pkg::ADDR_LEVEL, 32'h33);
        $display("dip done");
    endtask

    // masked, enabled, cleared
    task automatic t_irq();
        rchk(lvsrc_pkg::ADDR_IRQ_ST, 32'h1);
        chk(32'(irq), 32'h0);
        bus(1'b1, lvsrc_pkg::ADDR_IRQ_EN, 32'h1);
        cyc(2);
        chk(32'(irq), 32'h1);
        bus(1'b1, lvsrc_pkg::ADDR_IRQ_CLR, 32'h1);
        cyc(2);
        chk(32'(irq), 32'h0);
        rchk(lvsrc_pkg::ADDR_IRQ_ST, 32'h0);
        $display("irq done");
    endtask

    task automatic t_lowpow();
        int b;
        b = n_rst;
        low_power_mode <= 1'b1;
        cyc(3);
        chk(32'(supervise_en), 32'h0);
        supply_mv <= 12'h640;
        cyc(F + 12);
        supply_mv <= 12'hFA0;
        cyc(6);
        low_power_mode <= 1'b0;
        chk(32'(n_rst - b), 32'h0);
        $display("lowpow done");
    endtask

    // undefined code, then flag clearing
    task automatic t_badcode();
        int b;
        b = n_rst;
        bus(1'b1, lvsrc_pkg::ADDR_LEVEL, 32'h12);
        cyc(S - 3);
        chk(32'(n_rst - b), 32'h0);
        cyc(8);
        chk(32'(n_rst - b), 32'h1);
        rchk(lvsrc_pkg::ADDR_LEVEL, 32'h66);
        rchk(lvsrc_pkg::ADDR_CAUSE, 32'h6);
        bus(1'b1, lvsrc_pkg::ADDR_CAUSE, 32'h4);
        rchk(lvsrc_pkg::ADDR_CAUSE, 32'h4);
        bus(1'b1, lvsrc_pkg::ADDR_CAUSE, 32'h0);
        rchk(lvsrc_pkg::ADDR_CAUSE, 32'h0);
        $display("badcode done");
    endtask

    task automatic t_key();
        int b;
        b = n_rst;
        bus(1'b1, lvsrc_pkg::ADDR_PROG, 32'h54);
        cyc(4);
        chk(32'(n_rst - b), 32'h0);
        bus(1'b1, lvsrc_pkg::ADDR_PROG, 32'h55);
        cyc(4);
        chk(32'(n_rst - b), 32'h1);
        $display("key done");
    endtask

    // pulse the watchdog in the given power mode
    task automatic wdt(input logic lp);
        bus(1'b1, lvsrc_pkg::ADDR_LEVEL, 32'h99);
        low_power_mode <= lp;
        wdt_fire <= 1'b1;
        @(posedge clk);
        wdt_fire <= 1'b0;
        cyc(5);
        low_power_mode <= 1'b0;
    endtask

    task automatic t_wdt();
        int b, p;
        b = n_rst;
        p = n_pc;
        wdt(1'b0);
        chk(32'(n_rst - b), 32'h1);
        rchk(lvsrc_pkg::ADDR_STATUS, 32'h1);
        rchk(lvsrc_pkg::ADDR_LEVEL, 32'h66);
        bus(1'b1, lvsrc_pkg::ADDR_STATUS, 32'h0);
        wdt(1'b1);
        chk(32'(n_rst - b), 32'h1);
        chk(32'(n_pc - p), 32'h1);
        rchk(lvsrc_pkg::ADDR_STATUS, 32'h3);
        rchk(lvsrc_pkg::ADDR_LEVEL, 32'h99);
        $display("wdt done");
    endtask

    // reset in mid-run restores the power-on state
    task automatic t_rst();
        bus(1'b1, lvsrc_pkg::ADDR_LEVEL, 32'h33);
        nrst <= 1'b0;
        cyc(8);
        nrst <= 1'b1;
        rchk(lvsrc_pkg::ADDR_LEVEL, 32'h66);
        rchk(lvsrc_pkg::ADDR_STATUS, 32'h0);
        chk(32'(supervise_en), 32'h1);
        $display("rst done");
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // cut a hang short
    initial
    begin
        cyc(5000);
        err_total++;
        stop_test();
    end

    initial
    begin
        cyc(8);
        nrst <= 1'b1;
        t_por();
        t_decode();
        t_dip();
        t_irq();
        t_lowpow();
        t_badcode();
        t_key();
        t_wdt();
        t_rst();
        stop_test();
    end
endmodule
